// File: verilog/gucm_pkg.sv
package gucm_pkg;

    // Width of the count and of the match value.
    localparam int COUNT_WIDTH = 32;

    // Reset values of the count and of the match value.
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [31:0] MATCH_RESET = 32'hffff_ffff;

    // Length of the match pulse in system clock cycles.
    localparam int PULSE_CYCLES = 1;

    // Number of synchroniser stages for pins from outside the clock domain.
    localparam int SYNC_STAGES = 3;

    // Control request from the host side of the unit.
    typedef struct packed {
        logic load_match;
        logic clear_count;
        logic [31:0] match_value;
    } gucm_ctrl_type;

    // State shown back to the host side.
    typedef struct packed {
        logic [31:0] count;
        logic [31:0] match_value;
        logic match_seen;
    } gucm_stat_type;

endpackage

// File: verilog/gucm_counter.sv
// Overview of operation
// - The count advances only while the gate pin is high, and the outside source must hold it high to count.
// - Each rising edge of the count clock pin with the gate high and no clear adds one to the count; a clear, or a wrap from all ones, returns it to zero.
// - The count is a 32-bit binary number whose largest value is all ones.
// - When a step brings the count to the match value, one positive pulse appears on the match output.
// - The match output pin carries only the match indication and no other counter state.
`timescale 1ns/1ps

module gucm_counter
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic count_gate_in,
    input wire logic count_up_clock_in,
    input wire gucm_pkg::gucm_ctrl_type ctrl,
    output gucm_pkg::gucm_stat_type stat,
    output logic count_match_out
);

    // Filtered pin levels. The counting logic needs only the gate level and
    // the rising edge of the count clock, both on the system clock.
    logic gate_level;
    logic clk_rise;
    logic step;

    // Match value, count and match indication state.
    logic [31:0] match_reg;
    logic [31:0] match_next;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic pulse_reg;
    logic pulse_next;
    logic seen_reg;
    logic seen_next;
    logic hit;

    // The gate pin passes the same filter as the count clock, so a glitch on
    // the gate cannot open it for one stray count.
    gucm_pin_filter
    #(
        .STAGES(gucm_pkg::SYNC_STAGES)
    )
    u_gate_filter
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(count_gate_in),
        .level_out(gate_level),
        .rise_out()
    );

    // Only the rising edge of the count clock matters; its filtered level
    // is not needed here.
    gucm_pin_filter
    #(
        .STAGES(gucm_pkg::SYNC_STAGES)
    )
    u_clk_filter
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_in(count_up_clock_in),
        .level_out(),
        .rise_out(clk_rise)
    );

    // A filtered rising edge of the count clock while the gate is high. The
    // 200 MHz sampling keeps up with count clocks well above 5 MHz.
    assign step = clk_rise & gate_level;

    // Match value. A load takes effect at the next edge, and a step in the
    // same cycle is already compared against the new value.
    always_comb
    begin
        match_next = match_reg;
        if (ctrl.load_match)
        begin
            match_next = ctrl.match_value;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            match_reg <= gucm_pkg::MATCH_RESET;
        end
        else
        begin
            match_reg <= match_next;
        end
    end

    // Count. Clear has priority over a step in the same cycle; the lost edge
    // is the price of a clear that always leaves exactly zero behind.
    always_comb
    begin
        count_next = count_reg;
        if (ctrl.clear_count)
        begin
            count_next = gucm_pkg::COUNT_RESET;
        end
        else if (step)
        begin
            // The carry out of bit 31 is dropped, so all ones wraps to zero.
            count_next = count_reg + 32'h0000_0001;
        end
    end

    // Reset leaves the count at zero, just as a clear does.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            count_reg <= gucm_pkg::COUNT_RESET;
        end
        else
        begin
            count_reg <= count_next;
        end
    end

    // A match is a step that lands on the match value. Holding the count at
    // the match value, loading it or clearing onto it never gives a pulse.
    assign hit = step & ~ctrl.clear_count & (count_next == match_next);

    // Match pulse and the sticky match flag. A clear and a hit cannot meet in
    // one cycle, because hit itself is masked by ctrl.clear_count.
    always_comb
    begin
        pulse_next = 1'b0;
        seen_next = seen_reg;
        if (ctrl.clear_count)
        begin
            seen_next = 1'b0;
        end
        if (hit)
        begin
            pulse_next = 1'b1;
            seen_next = 1'b1;
        end
    end

    // The pulse register drives the pin directly, so the pin never glitches.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            pulse_reg <= 1'b0;
            seen_reg <= 1'b0;
        end
        else
        begin
            pulse_reg <= pulse_next;
            seen_reg <= seen_next;
        end
    end

    // The pin shows the match pulse and nothing else; the host side sees the
    // count, the match value and the sticky flag.
    assign count_match_out = pulse_reg;
    assign stat = '{count: count_reg, match_value: match_reg, match_seen: seen_reg};

endmodule

// Pin filter: a chain of flip-flops whose last two stages must agree before
// the filtered level follows, so a one-cycle glitch never counts. It needs at
// least two stages; three keep the first, possibly metastable, stage away
// from the comparison.
module gucm_pin_filter
#(
    parameter int STAGES = gucm_pkg::SYNC_STAGES
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic pin_in,
    output logic level_out,
    output logic rise_out
);

    // Shift chain and the filtered level. Stage 0 may go metastable, so only
    // stage 1 ever reads it.
    logic [STAGES-1:0] sync_reg;
    logic [STAGES-1:0] sync_next;
    logic level_reg;
    logic level_next;

    // A pin change counts once the last two stages agree; until then the
    // filtered level keeps its old value.
    always_comb
    begin
        sync_next = {sync_reg[STAGES-2:0], pin_in};
        level_next = level_reg;
        if (sync_reg[STAGES-2] == sync_reg[STAGES-1])
        begin
            level_next = sync_reg[STAGES-1];
        end
    end

    // The chain resets low, so a pin that is high at release shows as a rise
    // a few cycles later.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sync_reg <= '0;
            level_reg <= 1'b0;
        end
        else
        begin
            sync_reg <= sync_next;
            level_reg <= level_next;
        end
    end

    // The rise is seen one cycle before the level register follows, which
    // saves a cycle of latency on every count.
    assign level_out = level_reg;
    assign rise_out = level_next & ~level_reg;

endmodule

// File: test/gucm_counter_props.sv
`timescale 1ns/1ps
module gucm_props(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic count_gate_in,
    input wire logic count_up_clock_in,
    input wire gucm_pkg::gucm_ctrl_type ctrl,
    input wire gucm_pkg::gucm_stat_type stat,
    input wire logic count_match_out
);
    // A clear also moves the count, so a step leaves clears out.
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_step;
        $changed(stat.count) && !$past(ctrl.clear_count);
    endsequence
    a_step_one: assert property (s_step |-> stat.count == $past(stat.count) + 1)
        else $error("bad step");
    a_gate_shut: assert property ((!count_gate_in)[*8] |-> not s_step)
        else $error("gated step");
    a_pulse_iff: assert property (count_match_out == (stat.count == stat.match_value
        && $changed(stat.count) && !$past(ctrl.clear_count))) else $error("bad pulse");
    a_clear_zero: assert property (ctrl.clear_count |=> stat.count == 0) else $error("clr");
    a_clock_idle: assert property ((!count_up_clock_in)[*8] |-> not s_step)
        else $error("idle step");
    a_pulse_once: assert property (count_match_out |=> !count_match_out)
        else $error("long pulse");
    a_pulse_seen: assert property (count_match_out |-> stat.match_seen)
        else $error("flag not set");
    a_load_match: assert property (ctrl.load_match |=>
        stat.match_value == $past(ctrl.match_value)) else $error("bad load");
endmodule
bind gucm_counter gucm_props u_props(.*);

// File: test/gucm_src.sv
`timescale 1ns/1ps
module gucm_src(
    input wire logic clk_sys,
    output logic count_gate_in = 1'b0,
    output logic count_up_clock_in = 1'b0
);
    // The count clock rests low between bursts; three cycles a level suits the filters.
    task automatic run(input int n, input logic g);
        @(posedge clk_sys) count_gate_in <= g;
        repeat (n * 2)
        begin
            repeat (3) @(posedge clk_sys);
            count_up_clock_in <= ~count_up_clock_in;
        end
        repeat (6) @(posedge clk_sys);
    endtask
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic count_gate_in, count_up_clock_in, count_match_out;
    gucm_pkg::gucm_ctrl_type ctrl = '0;
    gucm_pkg::gucm_stat_type stat;
    int n_fail, checks, hits;
    // Clock, and a tally of pulse cycles so a stretched pulse shows too.
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) hits += (count_match_out === 1'b1);
    gucm_counter DUT(.*);
    gucm_src src(.*);
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) n_fail++;
        if (got !== exp) $display("CHECK FAILED %0t %h %h", $time, got, exp);
    endtask
    // A closed gate must freeze the count.
    task automatic t_gate;
        chk(stat.match_value, 32'hffff_ffff);
        chk(stat.match_seen, 32'h0);
        src.run(5, 1'b1);
        chk(stat.count, 32'h5);
        src.run(4, 1'b0);
        chk(stat.count, 32'h5);
        $display("t_gate done");
    endtask
    // One pulse per match, none on load or clear, and counting runs on.
    task automatic t_match;
        ctrl <= {2'b10, 32'h7};
        src.run(3, 1'b1);
        chk(hits, 1);
        chk(stat.count, 32'h8);
        chk(stat.match_seen, 32'h1);
        ctrl <= {2'b01, 32'h0};
        repeat (2) @(posedge clk_sys);
        chk(stat.count, 32'h0);
        chk(stat.match_seen, 32'h0);
        ctrl <= '0;
        src.run(7, 1'b1);
        chk(hits, 2);
        $display("t_match done");
    endtask
    task automatic stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Tests, then a watchdog far beyond the 150 or so cycles they need.
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_gate;
        t_match;
        stop_test;
    end
    initial
    begin
        #20000 n_fail++;
        stop_test;
    end
endmodule
